// ==== hw/tic_cfg.svh ====
// offsets, field positions, reset values and timing counts of the
// interval timer; assumes the includer needs plain text macros only
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

// register byte addresses on the plain register port
`define TIC_ADDR_CTRL 8'ha1
`define TIC_ADDR_SUBSEC 8'ha2
`define TIC_ADDR_SEC 8'ha3
`define TIC_ADDR_MIN 8'ha4
`define TIC_ADDR_HOUR 8'ha5
`define TIC_ADDR_COMPARE 8'ha6
`define TIC_ADDR_STATUS 8'ha7
`define TIC_ADDR_MASK 8'ha8

// control register fields
`define TIC_BIT_RESERVED 7
`define TIC_BIT_HOUR_RANGE 6
`define TIC_BIT_SEL_HI 5
`define TIC_BIT_SEL_LO 4
`define TIC_BIT_SINGLE 3
`define TIC_BIT_MATCH 2
`define TIC_BIT_COUNT_EN 1
`define TIC_BIT_CLOCK_EN 0

// status and mask fields
`define TIC_EVT_MATCH 0
`define TIC_EVT_SECOND 1

// reset values
`define TIC_RST_CTRL 8'h00
`define TIC_RST_TIME 8'h00
`define TIC_RST_COMPARE 8'h00
`define TIC_RST_MASK 2'h0

// counter limits
`define TIC_SUBSEC_LAST 8'h7f
`define TIC_SEC_LAST 8'h3b
`define TIC_MIN_LAST 8'h3b
`define TIC_HOUR_LAST_24 8'h17
`define TIC_HOUR_LAST_256 8'hff

// timing: one sub-second step is 1/128 s
`define TIC_CLK_PERIOD_NS 100
`define TIC_SUBSEC_PERIOD_NS 7812500
`define TIC_TICK_CYCLES \
    ((`TIC_SUBSEC_PERIOD_NS + `TIC_CLK_PERIOD_NS - 1) / `TIC_CLK_PERIOD_NS)
`define TIC_DIV_WIDTH 17

`endif

// ==== hw/tic_pkg.sv ====
// types shared by the interval timer files; assumes nothing else
`default_nettype none
package tic_pkg;

    // interval counter timebase select field
    typedef enum logic [1:0] {
        TB_SUBSEC = 2'h0,
        TB_SECOND = 2'h1,
        TB_MINUTE = 2'h2,
        TB_HOUR = 2'h3
    } timebase_e;

    typedef logic [7:0] byte_t;

endpackage
`default_nettype wire

// ==== hw/tick_divider.sv ====
// sub-second tick divider: one pulse every 1/128 s of ref_clk
// assumes a single ref_clk domain and a level run enable
`timescale 1ns/10ps
`default_nettype none
`include "tic_cfg.svh"

module tick_divider
    import tic_pkg::*;
#(
    parameter int TICK_CYCLES = `TIC_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic run,
    output logic tick
);

    localparam logic [`TIC_DIV_WIDTH-1:0] LAST_COUNT =
        `TIC_DIV_WIDTH'(TICK_CYCLES - 1);

    logic [`TIC_DIV_WIDTH-1:0] divCount;
    logic [`TIC_DIV_WIDTH-1:0] next_divCount;
    logic next_tick;

    // restart from zero whenever stopped so the first step is whole
    always_comb begin
        next_divCount = divCount;
        next_tick = 1'b0;
        if (!run) begin
            next_divCount = '0;
        end else if (divCount == LAST_COUNT) begin
            next_divCount = '0;
            next_tick = 1'b1;
        end else begin
            next_divCount = `TIC_DIV_WIDTH'(divCount + 1'b1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            divCount <= '0;
            tick <= 1'b0;
        end else if (clkEn) begin
            divCount <= next_divCount;
            tick <= next_tick;
        end
    end

endmodule
`default_nettype wire

// ==== hw/time_interval_counter.sv ====
// time counters, interval counter, compare and register port
// assumes a one-cycle strobe master on ref_clk and a level irq consumer
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "tic_cfg.svh"

// Summary of operation
// - With hour range select set the hour wraps after 23, else after 255.
// - Timebase select bits 5:4 pick 1/128 s, second, minute or hour steps.
// - Single interval mode makes a timeout clear the count enable bit.
// - Without single interval mode the interval counter reloads and runs on.
// - Counter equal to the compare value sets a sticky match flag.
// - The match flag raises the interrupt only when its mask bit is set.
// - The count enable bit runs the interval counter or stops it.
// - The timebase clock enable bit passes the time steps to all counters.
// - Clearing clock enable stops counting and restores last written times.
// - Time registers take software writes while clock enable is low.
// - The compare register at a6 is eight bits, written by software, reset 0.
// - Control bit 7 is reserved and reads as zero.
// - All counting is paced by a 1/128 s step derived from the clock.
// - The sub-second counter steps 0 to 127 and carries into seconds.
// - The seconds counter steps 0 to 59 and carries into minutes.
// - The minutes counter steps 0 to 59 and carries into hours.
module time_interval_counter
    import tic_pkg::*;
#(
    parameter int TICK_CYCLES = `TIC_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [7:0] addr,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    output logic irq
);

    // step one counter with wrap at its last value
    function automatic byte_t stepCount(input byte_t value,
                                        input logic advance,
                                        input byte_t last);
        if (!advance) begin
            return value;
        end
        if (value >= last) begin
            return 8'h00;
        end
        return byte_t'(value + 8'h01);
    endfunction

    function automatic logic hitReg(input logic strobe, input byte_t a,
                                    input byte_t target);
        return strobe && (a == target);
    endfunction

    logic subTick;
    logic hourRange, singleMode, matchFlag, countEn, clockEn;
    timebase_e timebase;
    byte_t subsec, sec, minute, hour;
    byte_t subsecWr, secWr, minuteWr, hourWr;
    byte_t compare, intCount;
    logic secEvent;
    logic [1:0] mask;

    logic next_hourRange, next_singleMode, next_matchFlag;
    logic next_countEn, next_clockEn;
    timebase_e next_timebase;
    byte_t next_subsec, next_sec, next_minute, next_hour;
    byte_t next_subsecWr, next_secWr, next_minuteWr, next_hourWr;
    byte_t next_compare, next_intCount;
    logic next_secEvent;
    logic [1:0] next_mask;
    logic next_irq;
    byte_t next_readData;

    logic stepNow, subWrap, secWrap, minWrap, intervalTick;
    logic intAdvance, matchNow;
    byte_t incCount, hourLast;
    logic wrCtrl, wrStatus, timeWrOk;

    tick_divider #(
        .TICK_CYCLES(TICK_CYCLES)
    ) divider (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .run(clockEn),
        .tick(subTick)
    );

    // carry chain through the time counters
    always_comb begin
        stepNow = clockEn && subTick;
        subWrap = stepNow && (subsec >= `TIC_SUBSEC_LAST);
        secWrap = subWrap && (sec >= `TIC_SEC_LAST);
        minWrap = secWrap && (minute >= `TIC_MIN_LAST);
        hourLast = hourRange ? `TIC_HOUR_LAST_24 : `TIC_HOUR_LAST_256;
        unique case (timebase)
            TB_SUBSEC: intervalTick = stepNow;
            TB_SECOND: intervalTick = subWrap;
            TB_MINUTE: intervalTick = secWrap;
            TB_HOUR: intervalTick = minWrap;
        endcase
        intAdvance = clockEn && countEn && intervalTick;
        incCount = byte_t'(intCount + 8'h01);
        matchNow = intAdvance && (incCount == compare);
    end

    // time registers: shadows hold what software last wrote
    always_comb begin
        timeWrOk = writeStrobe && !clockEn;
        next_subsecWr = subsecWr;
        next_secWr = secWr;
        next_minuteWr = minuteWr;
        next_hourWr = hourWr;
        if (hitReg(timeWrOk, addr, `TIC_ADDR_SUBSEC)) begin
            next_subsecWr = writeData;
        end
        if (hitReg(timeWrOk, addr, `TIC_ADDR_SEC)) begin
            next_secWr = writeData;
        end
        if (hitReg(timeWrOk, addr, `TIC_ADDR_MIN)) begin
            next_minuteWr = writeData;
        end
        if (hitReg(timeWrOk, addr, `TIC_ADDR_HOUR)) begin
            next_hourWr = writeData;
        end
        // stopped counters simply mirror the shadows
        if (clockEn) begin
            next_subsec = stepCount(subsec, stepNow, `TIC_SUBSEC_LAST);
            next_sec = stepCount(sec, subWrap, `TIC_SEC_LAST);
            next_minute = stepCount(minute, secWrap, `TIC_MIN_LAST);
            next_hour = stepCount(hour, minWrap, hourLast);
        end else begin
            next_subsec = next_subsecWr;
            next_sec = next_secWr;
            next_minute = next_minuteWr;
            next_hour = next_hourWr;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            subsec <= `TIC_RST_TIME;
            sec <= `TIC_RST_TIME;
            minute <= `TIC_RST_TIME;
            hour <= `TIC_RST_TIME;
            subsecWr <= `TIC_RST_TIME;
            secWr <= `TIC_RST_TIME;
            minuteWr <= `TIC_RST_TIME;
            hourWr <= `TIC_RST_TIME;
        end else if (clkEn) begin
            subsec <= next_subsec;
            sec <= next_sec;
            minute <= next_minute;
            hour <= next_hour;
            subsecWr <= next_subsecWr;
            secWr <= next_secWr;
            minuteWr <= next_minuteWr;
            hourWr <= next_hourWr;
        end
    end

    // control, interval counter, flags, mask, read port
    always_comb begin
        wrCtrl = hitReg(writeStrobe, addr, `TIC_ADDR_CTRL);
        wrStatus = hitReg(writeStrobe, addr, `TIC_ADDR_STATUS);
        next_hourRange = hourRange;
        next_timebase = timebase;
        next_singleMode = singleMode;
        next_countEn = countEn;
        next_clockEn = clockEn;
        next_matchFlag = matchFlag;
        next_secEvent = secEvent;
        next_mask = mask;
        next_compare = compare;
        // a timeout in single mode drops the enable; a same-cycle write wins
        if (matchNow && singleMode) begin
            next_countEn = 1'b0;
        end
        if (wrCtrl) begin
            next_hourRange = writeData[`TIC_BIT_HOUR_RANGE];
            next_timebase = timebase_e'(
                writeData[`TIC_BIT_SEL_HI:`TIC_BIT_SEL_LO]);
            next_singleMode = writeData[`TIC_BIT_SINGLE];
            next_countEn = writeData[`TIC_BIT_COUNT_EN];
            next_clockEn = writeData[`TIC_BIT_CLOCK_EN];
            if (!writeData[`TIC_BIT_MATCH]) begin
                next_matchFlag = 1'b0;
            end
        end
        if (wrStatus && writeData[`TIC_EVT_MATCH]) begin
            next_matchFlag = 1'b0;
        end
        if (wrStatus && writeData[`TIC_EVT_SECOND]) begin
            next_secEvent = 1'b0;
        end
        // hardware set beats a clear in the same cycle
        if (matchNow) begin
            next_matchFlag = 1'b1;
        end
        if (subWrap) begin
            next_secEvent = 1'b1;
        end
        if (hitReg(writeStrobe, addr, `TIC_ADDR_MASK)) begin
            next_mask = writeData[1:0];
        end
        if (hitReg(writeStrobe, addr, `TIC_ADDR_COMPARE)) begin
            next_compare = writeData;
        end
        // counting from zero again after each timeout
        if (!countEn || matchNow) begin
            next_intCount = 8'h00;
        end else if (intAdvance) begin
            next_intCount = incCount;
        end else begin
            next_intCount = intCount;
        end
        next_irq = |({next_secEvent, next_matchFlag} & next_mask);
        next_readData = 8'h00;
        if (readStrobe) begin
            unique case (addr)
                `TIC_ADDR_CTRL: next_readData = {1'b0, hourRange, timebase,
                    singleMode, matchFlag, countEn, clockEn};
                `TIC_ADDR_SUBSEC: next_readData = subsec;
                `TIC_ADDR_SEC: next_readData = sec;
                `TIC_ADDR_MIN: next_readData = minute;
                `TIC_ADDR_HOUR: next_readData = hour;
                `TIC_ADDR_COMPARE: next_readData = compare;
                `TIC_ADDR_STATUS: next_readData = {6'h00, secEvent, matchFlag};
                `TIC_ADDR_MASK: next_readData = {6'h00, mask};
                default: next_readData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hourRange <= 1'b0;
            timebase <= TB_SUBSEC;
            singleMode <= 1'b0;
            countEn <= 1'b0;
            clockEn <= 1'b0;
            matchFlag <= 1'b0;
            secEvent <= 1'b0;
            mask <= `TIC_RST_MASK;
            compare <= `TIC_RST_COMPARE;
            intCount <= 8'h00;
            irq <= 1'b0;
            readData <= 8'h00;
        end else if (clkEn) begin
            hourRange <= next_hourRange;
            timebase <= next_timebase;
            singleMode <= next_singleMode;
            countEn <= next_countEn;
            clockEn <= next_clockEn;
            matchFlag <= next_matchFlag;
            secEvent <= next_secEvent;
            mask <= next_mask;
            compare <= next_compare;
            intCount <= next_intCount;
            irq <= next_irq;
            readData <= next_readData;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_hour_wrap: assert property (clkEn && clockEn && minWrap && hourRange
        && hour == 8'h17 |=> hour == 8'h00)
        else $error("hour did not wrap after 23");
    a_timebase_step: assert property (clkEn && intAdvance && !matchNow
        && !wrCtrl |=> intCount == $past(intCount) + 8'h01)
        else $error("interval counter missed its selected step");
    a_single_shot: assert property (clkEn && matchNow && singleMode
        && !wrCtrl |=> !countEn)
        else $error("single mode timeout left counting enabled");
    a_auto_reload: assert property (clkEn && matchNow && !singleMode
        && !wrCtrl |=> countEn && intCount == 8'h00)
        else $error("auto reload did not restart the counter");
    a_match_flag: assert property (clkEn && matchNow |=> matchFlag)
        else $error("match did not set the flag");
    // a masked match alone must never reach the line; a second event may
    a_irq_masked: assert property (!mask[0]
        && !(mask[1] && (secEvent || subWrap)) && !wrStatus
        && !hitReg(writeStrobe, addr, `TIC_ADDR_MASK) && clkEn
        |=> !irq)
        else $error("interrupt raised while masked");
    a_count_clear: assert property (clkEn && !countEn
        |=> intCount == 8'h00)
        else $error("disabled interval counter not cleared");
    a_subsec_step: assert property (clkEn && stepNow && subsec < 8'h7f
        |=> subsec == $past(subsec) + 8'h01)
        else $error("sub-second counter did not step");
    a_time_restore: assert property (clkEn && !clockEn
        |=> sec == secWr && minute == minuteWr && hour == hourWr)
        else $error("stopped time not restored to written value");
    a_write_guard: assert property (clkEn && clockEn
        |=> $stable(secWr) && $stable(hourWr))
        else $error("time shadow changed while running");
    a_compare_write: assert property (clkEn
        && hitReg(writeStrobe, addr, `TIC_ADDR_COMPARE)
        |=> compare == $past(writeData))
        else $error("compare register did not take the write");
    a_reserved_zero: assert property (!readData[7] || $past(addr)
        != `TIC_ADDR_CTRL || !$past(readStrobe) || !$past(clkEn))
        else $error("reserved control bit read as one");
    a_sec_wrap: assert property (clkEn && subWrap && sec == 8'h3b
        |=> sec == 8'h00 && minute != $past(minute))
        else $error("seconds did not wrap into minutes");
    a_min_wrap: assert property (clkEn && secWrap && minute == 8'h3b
        |=> minute == 8'h00)
        else $error("minutes did not wrap");
    a_subsec_wrap: assert property (clkEn && stepNow && subsec == 8'h7f
        |=> subsec == 8'h00)
        else $error("sub-second counter did not wrap at 127");

    c_single_timeout: cover property (matchNow && singleMode);
    c_reload_timeout: cover property (matchNow && !singleMode);
    c_irq_raised: cover property (irq && matchFlag);
    c_restore: cover property (clockEn ##1 !clockEn);

endmodule
`default_nettype wire

// ==== testbench/time_interval_counter_bench.sv ====
// bench for the interval timer: register port tasks and test sequences
// assumes the design carries its own assertions; one 10 MHz clock only
`timescale 1ns/10ps
`default_nettype none
`include "tic_cfg.svh"

module time_interval_counter_bench
    import tic_pkg::*;
;
    localparam int TICKS = 4;

    logic ref_clk;
    logic reset;
    logic clkEn;
    logic [7:0] addr;
    logic [7:0] writeData;
    logic writeStrobe;
    logic readStrobe;
    logic [7:0] readData;
    logic irq;
    int nFail = 0;
    int checksDone = 0;
    // preloads per timebase: for second, minute and hour, step two is the first carry into that level
    byte_t preSec [4] = '{8'h00, 8'h00, 8'h3b, 8'h3b};
    byte_t preMin [4] = '{8'h00, 8'h00, 8'h00, 8'h3b};

    time_interval_counter #(
        .TICK_CYCLES(TICKS)
    ) i_dut (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .addr(addr),
        .writeData(writeData),
        .writeStrobe(writeStrobe),
        .readStrobe(readStrobe),
        .readData(readData),
        .irq(irq)
    );

    // free-running 100 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic closeOut();
        $display("checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input byte_t seen, input byte_t exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // one-cycle write strobe, released at the edge that takes it
    task automatic wr(input byte_t a, input byte_t d);
        @(posedge ref_clk);
        addr <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge ref_clk);
        writeStrobe <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rdChk(input byte_t a, input byte_t exp, input byte_t m);
        @(posedge ref_clk);
        addr <= a;
        readStrobe <= 1'b1;
        @(posedge ref_clk);
        readStrobe <= 1'b0;
        #1;
        chk(readData & m, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // counts edges until irq is seen; a hang ends the run
    task automatic waitIrq(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            #1;
        end while (irq !== 1'b1 && n < 2000);
        if (irq !== 1'b1) begin
            chk({7'h00, irq}, 8'h01);
            closeOut();
        end
    endtask

    initial begin
        int n;
        reset = 1'b1;
        clkEn = 1'b1;
        addr = 8'h00;
        writeData = 8'h00;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;

        // reset values, read-back, reserved bit, unmapped place
        rdChk(`TIC_ADDR_CTRL, 8'h00, 8'hff);
        rdChk(`TIC_ADDR_COMPARE, 8'h00, 8'hff);
        rdChk(`TIC_ADDR_HOUR, 8'h00, 8'hff);
        rdChk(`TIC_ADDR_SUBSEC, 8'h00, 8'hff);
        wr(`TIC_ADDR_COMPARE, 8'hff);
        rdChk(`TIC_ADDR_COMPARE, 8'hff, 8'hff);
        wr(`TIC_ADDR_CTRL, 8'h80);
        rdChk(`TIC_ADDR_CTRL, 8'h00, 8'hff);
        wr(8'h10, 8'h55);
        rdChk(8'h10, 8'h00, 8'hff);
        // a write with the clock enable low must be lost
        @(posedge ref_clk);
        clkEn <= 1'b0;
        wr(`TIC_ADDR_COMPARE, 8'h12);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        rdChk(`TIC_ADDR_COMPARE, 8'hff, 8'hff);
        $display("test registers done");

        // carries through every level, restore on stop, write lockout
        wr(`TIC_ADDR_SUBSEC, 8'h7f);
        wr(`TIC_ADDR_SEC, 8'h3b);
        wr(`TIC_ADDR_MIN, 8'h3b);
        wr(`TIC_ADDR_HOUR, 8'h17);
        wr(`TIC_ADDR_CTRL, 8'h41);
        idle(8);
        rdChk(`TIC_ADDR_HOUR, 8'h00, 8'hff);
        rdChk(`TIC_ADDR_MIN, 8'h00, 8'hff);
        rdChk(`TIC_ADDR_SEC, 8'h00, 8'hff);
        wr(`TIC_ADDR_HOUR, 8'h05);
        rdChk(`TIC_ADDR_HOUR, 8'h00, 8'hff);
        wr(`TIC_ADDR_CTRL, 8'h40);
        rdChk(`TIC_ADDR_HOUR, 8'h17, 8'hff);
        rdChk(`TIC_ADDR_SUBSEC, 8'h7f, 8'hff);
        wr(`TIC_ADDR_CTRL, 8'h01);
        idle(8);
        rdChk(`TIC_ADDR_HOUR, 8'h18, 8'hff);
        wr(`TIC_ADDR_CTRL, 8'h00);
        wr(`TIC_ADDR_HOUR, 8'hff);
        wr(`TIC_ADDR_CTRL, 8'h01);
        idle(8);
        rdChk(`TIC_ADDR_HOUR, 8'h00, 8'hff);
        $display("test time counters done");

        // every timebase in single mode; step one is 5 edges, step two 9
        wr(`TIC_ADDR_MASK, 8'h01);
        wr(`TIC_ADDR_COMPARE, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(`TIC_ADDR_CTRL, 8'h00);
            wr(`TIC_ADDR_STATUS, 8'h03);
            wr(`TIC_ADDR_SUBSEC, 8'h7e);
            wr(`TIC_ADDR_SEC, preSec[s]);
            wr(`TIC_ADDR_MIN, preMin[s]);
            chk({7'h00, irq}, 8'h00);
            wr(`TIC_ADDR_CTRL, byte_t'(s << 4) | 8'h0b);
            waitIrq(n);
            chk(byte_t'(n), (s == 0) ? 8'h05 : 8'h09);
            rdChk(`TIC_ADDR_CTRL, byte_t'(s << 4) | 8'h0d, 8'hff);
        end
        $display("test timebase done");

        // flag is sticky, mask gates the request line
        wr(`TIC_ADDR_MASK, 8'h00);
        idle(2);
        chk({7'h00, irq}, 8'h00);
        rdChk(`TIC_ADDR_STATUS, 8'h01, 8'h01);
        wr(`TIC_ADDR_MASK, 8'h01);
        idle(2);
        chk({7'h00, irq}, 8'h01);
        wr(`TIC_ADDR_STATUS, 8'h01);
        idle(2);
        chk({7'h00, irq}, 8'h00);
        rdChk(`TIC_ADDR_STATUS, 8'h00, 8'h01);
        rdChk(`TIC_ADDR_STATUS, 8'h02, 8'h02);
        $display("test mask done");

        // auto reload: each interval restarts from zero
        wr(`TIC_ADDR_CTRL, 8'h00);
        wr(`TIC_ADDR_COMPARE, 8'h02);
        wr(`TIC_ADDR_CTRL, 8'h03);
        waitIrq(n);
        chk(byte_t'(n), 8'h09);
        wr(`TIC_ADDR_STATUS, 8'h01);
        waitIrq(n);
        chk(byte_t'(n), 8'h06);
        rdChk(`TIC_ADDR_CTRL, 8'h07, 8'hff);
        // no step without the timebase clock, none without count enable
        wr(`TIC_ADDR_CTRL, 8'h02);
        wr(`TIC_ADDR_STATUS, 8'h01);
        idle(20);
        chk({7'h00, irq}, 8'h00);
        wr(`TIC_ADDR_CTRL, 8'h01);
        idle(20);
        rdChk(`TIC_ADDR_STATUS, 8'h00, 8'h01);
        wr(`TIC_ADDR_CTRL, 8'h03);
        waitIrq(n);
        // divider kept running since the last start, so step one comes
        // one edge after the write; a stale count would match at once
        chk(byte_t'(n), 8'h05);
        $display("test reload done");

        closeOut();
    end
endmodule

`default_nettype wire
